// ### uer_eng.sv
// Serial engine and host stand-in: transaction reports, received bytes, line levels
`timescale 1ns/1ps
module uer_eng (
  // Clock
  input wire logic core_clk,
  // Engine strobes
  output logic setup_data_start,
  output logic setup_ack_start,
  output logic txn_valid,
  output uer_pkg::uer_txn_t txn,
  // Received bytes
  output logic rx_valid,
  output uer_pkg::uer_wbyte_t rx_byte,
  input wire logic rx_ready,
  // Bus lines
  output logic dp_pin,
  output logic dm_pin
);
  logic rdy_s;
  initial begin
    {setup_data_start, setup_ack_start, txn_valid, rx_valid, dp_pin, dm_pin} = 6'h01;
    txn = '0;
    rx_byte = '0;
  end
  always @(negedge core_clk) rdy_s = rx_ready;
  task automatic pulse(input logic ack);
    @(posedge core_clk) #1;
    {setup_data_start, setup_ack_start} = {!ack, ack};
    @(posedge core_clk) #1;
    {setup_data_start, setup_ack_start} = 2'b00;
  endtask
  task automatic report(input logic [1:0] ep, input uer_pkg::uer_tok_t tok, input logic dv, input logic [3:0] cnt,
                        input logic tog);
    @(posedge core_clk) #1;
    txn_valid = 1'b1;
    txn = '{ep, tok, 1'b1, dv, cnt, tog};
    @(posedge core_clk) #1;
    txn_valid = 1'b0;
    txn = uer_pkg::uer_txn_t'(~txn);
  endtask
  task automatic send(input logic [1:0] ep, input logic [2:0] idx, input logic [7:0] d);
    @(posedge core_clk) #1;
    rx_valid = 1'b1;
    rx_byte = '{ep, idx, d};
    @(posedge core_clk);
    for (int n = 0; n < 50 && !rdy_s; n++) @(posedge core_clk);
    #1 rx_valid = 1'b0;
    rx_byte = uer_pkg::uer_wbyte_t'(~rx_byte);
  endtask
  task automatic se0(input int n);
    @(posedge core_clk) #1;
    {dp_pin, dm_pin} = 2'b00;
    repeat (n) @(posedge core_clk);
    #1 dm_pin = 1'b1;
  endtask
endmodule

// ### uer_ep_mem.sv
// Three eight-byte endpoint buffers with registered read data
`timescale 1ns/1ps
module uer_ep_mem #(
  parameter int EPS = 3,
  parameter int DEPTH = 8
) (
  // Clock
  input wire logic core_clk,
  // Write port
  input wire logic we,
  input wire logic [1:0] wep,
  input wire logic [2:0] widx,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [1:0] rep,
  input wire logic [2:0] ridx,
  output logic [7:0] rdata
);
  logic [7:0] mem [EPS*DEPTH];
  wire [4:0] waddr = 5'(wep * DEPTH + widx);
  wire [4:0] raddr = 5'(rep * DEPTH + ridx);

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ### uer_pkg.sv
// Constants and types for the endpoint register logic
package uer_pkg;
  // ----------------------------------------
  // I/O register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_FUNC = 8'h10;
  localparam logic [7:0] ADDR_EP0_CNT = 8'h11;
  localparam logic [7:0] ADDR_EP0_MODE = 8'h12;
  localparam logic [7:0] ADDR_EP1_CNT = 8'h13;
  localparam logic [7:0] ADDR_EP1_MODE = 8'h14;
  localparam logic [7:0] ADDR_EP2_CNT = 8'h15;
  localparam logic [7:0] ADDR_EP2_MODE = 8'h16;
  // ----------------------------------------
  // Endpoint buffer memory windows
  // ----------------------------------------
  localparam logic [7:0] BUF_EP2_BASE = 8'he8;
  localparam logic [7:0] BUF_EP1_BASE = 8'hf0;
  localparam logic [7:0] BUF_EP0_BASE = 8'hf8;
  localparam logic [7:0] BUF_LOCK_LO = 8'he0;
  localparam logic [7:0] BUF_LOCK_LO_END = 8'he7;
  localparam logic [7:0] BUF_LOCK_HI = 8'hf8;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int ADDR_EN_BIT = 7;
  localparam int SETUP_BIT = 7;
  localparam int IN_BIT = 6;
  localparam int OUT_BIT = 5;
  localparam int ACK_BIT = 4;
  localparam int TOGGLE_BIT = 7;
  localparam int VALID_BIT = 6;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] EP12_MODE_MASK = 8'h1f;
  localparam logic [3:0] MAX_COUNT = 4'h8;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 100;
  localparam int BUS_RESET_NS = 8000;
  localparam int BUS_RESET_CYC = BUS_RESET_NS / CLK_NS + 1;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    TOK_SETUP,
    TOK_IN,
    TOK_OUT
  } uer_tok_t;
  // End-of-transaction report from the serial engine
  typedef struct packed {
    logic [1:0] ep;
    uer_tok_t tok;
    logic acked;
    logic data_valid;
    logic [3:0] count;
    logic toggle;
  } uer_txn_t;
  // Byte written by the engine into an endpoint buffer
  typedef struct packed {
    logic [1:0] ep;
    logic [2:0] idx;
    logic [7:0] data;
  } uer_wbyte_t;
endpackage

// ### uer_top.sv
// Endpoint register logic for a low-speed USB function
// ----------------------------------------
// Overview of operation
// - Address register clears on reset, bus reset
// - Address matching only when enable bit set
// - Each endpoint has eight-byte buffer
// - Endpoint zero handles setup, IN, OUT
// - Mode registers clear on reset
// - Sticky token flags; firmware clears them
// - Endpoints one, two keep no token flags
// - Acknowledge flag set on ACKed transaction
// - Setup flag held until first read
// - Endpoint zero engine update locks its register writes until read
// - Setup flag blocks buffer writes E0-E7, F8-FF
// - Low mode bits select endpoint response
// - Counter low bits give IN byte count
// - Data-valid applies to OUT, setup only
// - Counter top bit holds data toggle
// - Bus reset after SE0 over 8 us
// ----------------------------------------
`timescale 1ns/1ps
module uer_top #(
  parameter int BUS_RESET_CYC = uer_pkg::BUS_RESET_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Processor I/O port
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Processor data memory port into the buffers
  input wire logic mem_wr,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata,
  // Bus line levels
  input wire logic dp_pin,
  input wire logic dm_pin,
  // Serial engine: setup data phase start and ACK start
  input wire logic setup_data_start,
  input wire logic setup_ack_start,
  // Serial engine: end-of-transaction report
  input wire logic txn_valid,
  input wire uer_pkg::uer_txn_t txn,
  // Serial engine: received bytes, buffered one at a time (ready only while buffer empty)
  input wire logic rx_valid,
  input wire uer_pkg::uer_wbyte_t rx_byte,
  output logic rx_ready,
  // Serial engine view of the registers
  output logic addr_match_en,
  output logic [6:0] func_addr,
  output logic [3:0] ep0_resp,
  output logic [3:0] ep1_resp,
  output logic [3:0] ep2_resp,
  output logic bus_reset
);
  // ----------------------------------------
  // Pin synchronisers and bus reset detect
  // ----------------------------------------
  logic [1:0] dp_sync_reg, dm_sync_reg;
  logic [15:0] se0_cnt_reg;
  logic bus_reset_reg;
  wire se0 = !dp_sync_reg[1] && !dm_sync_reg[1];
  wire se0_long = se0_cnt_reg >= 16'(BUS_RESET_CYC);

  always_ff @(posedge core_clk) begin
    dp_sync_reg <= {dp_sync_reg[0], dp_pin};
    dm_sync_reg <= {dm_sync_reg[0], dm_pin};
    if (srst || !se0) begin
      se0_cnt_reg <= 16'h0000;
    end else if (!se0_long) begin
      se0_cnt_reg <= se0_cnt_reg + 16'h0001;
    end
    bus_reset_reg <= !srst && se0_long;
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_func = io_wr && io_addr == uer_pkg::ADDR_FUNC;
  wire wr_mode0 = io_wr && io_addr == uer_pkg::ADDR_EP0_MODE;
  wire rd_mode0 = io_rd && io_addr == uer_pkg::ADDR_EP0_MODE;
  wire wr_cnt0 = io_wr && io_addr == uer_pkg::ADDR_EP0_CNT;
  wire [2:0] wr_cnt = {io_wr && io_addr == uer_pkg::ADDR_EP2_CNT,
                       io_wr && io_addr == uer_pkg::ADDR_EP1_CNT, wr_cnt0};
  wire [2:0] wr_mode = {io_wr && io_addr == uer_pkg::ADDR_EP2_MODE,
                        io_wr && io_addr == uer_pkg::ADDR_EP1_MODE, wr_mode0};

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] func_reg;
  logic [7:0] mode_reg [3];
  logic [7:0] cnt_reg [3];
  logic lock_reg;
  logic setup_hold_reg;
  logic setup_protect_reg;
  wire setup_flag = mode_reg[0][uer_pkg::SETUP_BIT];
  wire [1:0] tep = txn.ep;
  wire txn_ok = txn_valid && tep < 2'd3;

  always_ff @(posedge core_clk) begin
    if (srst || bus_reset_reg) begin
      func_reg <= uer_pkg::REG_RESET;
    end else if (wr_func) begin
      func_reg <= io_wdata;
    end
  end

  // Setup interval: held from data phase to ACK, then protected until read
  always_ff @(posedge core_clk) begin
    if (srst) begin
      setup_hold_reg <= 1'b0;
      setup_protect_reg <= 1'b0;
    end else begin
      if (setup_data_start) begin
        setup_hold_reg <= 1'b1;
      end else if (setup_ack_start) begin
        setup_hold_reg <= 1'b0;
      end
      if (setup_data_start) begin
        setup_protect_reg <= 1'b1;
      end else if (rd_mode0 && !setup_hold_reg) begin
        setup_protect_reg <= 1'b0;
      end
    end
  end

  // Lock set by endpoint zero engine update, lifted by later read; set wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lock_reg <= 1'b0;
    end else if (txn_ok && tep == 2'd0) begin
      lock_reg <= 1'b1;
    end else if (rd_mode0) begin
      lock_reg <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ep
      wire eng = txn_ok && tep == 2'(g);
      wire [7:0] keep = (g == 0) ? 8'hff : uer_pkg::EP12_MODE_MASK;
      logic [7:0] mode_next;
      logic [7:0] cnt_next;
      always_comb begin
        mode_next = mode_reg[g];
        cnt_next = cnt_reg[g];
        if (wr_mode[g] && !(g == 0 && lock_reg)) begin
          mode_next = io_wdata & keep;
          if (g == 0 && (setup_hold_reg || setup_protect_reg)) begin
            mode_next[uer_pkg::SETUP_BIT] = 1'b1;
          end
        end
        if (g == 0 && setup_hold_reg) begin
          mode_next[uer_pkg::SETUP_BIT] = 1'b1;
        end
        if (wr_cnt[g] && !(g == 0 && lock_reg)) begin
          cnt_next = io_wdata;
        end
        if (eng) begin
          if (txn.acked) begin
            mode_next[uer_pkg::ACK_BIT] = 1'b1;
          end
          if (g == 0) begin
            unique case (txn.tok)
              uer_pkg::TOK_SETUP: mode_next[uer_pkg::SETUP_BIT] = 1'b1;
              uer_pkg::TOK_IN: mode_next[uer_pkg::IN_BIT] = 1'b1;
              uer_pkg::TOK_OUT: mode_next[uer_pkg::OUT_BIT] = 1'b1;
              default: mode_next = mode_next;
            endcase
          end
          if (txn.tok != uer_pkg::TOK_IN) begin
            cnt_next[uer_pkg::VALID_BIT] = txn.data_valid;
            cnt_next[3:0] = txn.count;
            cnt_next[uer_pkg::TOGGLE_BIT] = txn.toggle;
          end
        end
      end
      always_ff @(posedge core_clk) begin
        if (srst) begin
          mode_reg[g] <= uer_pkg::REG_RESET;
          cnt_reg[g] <= uer_pkg::REG_RESET;
        end else begin
          mode_reg[g] <= mode_next;
          cnt_reg[g] <= cnt_next;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Two-slot buffer for engine bytes, taking a new byte only when empty
  // ----------------------------------------
  uer_pkg::uer_wbyte_t fifo_reg [2];
  logic [1:0] fifo_cnt_reg;
  logic rd_ptr_reg, wr_ptr_reg;
  wire [7:0] buf_addr = mem_addr;
  wire in_ep0 = buf_addr >= uer_pkg::BUF_LOCK_HI;
  wire in_ep1 = buf_addr >= uer_pkg::BUF_EP1_BASE && !in_ep0;
  wire in_ep2 = buf_addr >= uer_pkg::BUF_EP2_BASE && buf_addr < uer_pkg::BUF_EP1_BASE;
  wire in_lock = (buf_addr >= uer_pkg::BUF_LOCK_LO && buf_addr <= uer_pkg::BUF_LOCK_LO_END) || in_ep0;
  wire cpu_buf_wr = mem_wr && (in_ep0 || in_ep1 || in_ep2) && !(setup_flag && in_lock);
  wire [1:0] cpu_ep = in_ep0 ? 2'd0 : (in_ep1 ? 2'd1 : 2'd2);
  wire fifo_out_valid = fifo_cnt_reg != 2'd0;
  wire fifo_pop = fifo_out_valid && !cpu_buf_wr;
  wire fifo_push = rx_valid && rx_ready;
  uer_pkg::uer_wbyte_t head;
  assign head = fifo_reg[rd_ptr_reg];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fifo_cnt_reg <= 2'd0;
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      rx_ready <= 1'b0;
    end else begin
      if (fifo_push) begin
        fifo_reg[wr_ptr_reg] <= rx_byte;
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (fifo_pop) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
      fifo_cnt_reg <= fifo_cnt_reg + 2'(fifo_push) - 2'(fifo_pop);
      rx_ready <= (fifo_cnt_reg + 2'(fifo_push) - 2'(fifo_pop)) == 2'd0;
    end
  end

  // ----------------------------------------
  // Endpoint buffers
  // ----------------------------------------
  uer_ep_mem #(.EPS(3), .DEPTH(8)) u_mem (
    .core_clk(core_clk),
    .we(cpu_buf_wr || fifo_pop),
    .wep(cpu_buf_wr ? cpu_ep : head.ep),
    .widx(cpu_buf_wr ? buf_addr[2:0] : head.idx),
    .wdata(cpu_buf_wr ? mem_wdata : head.data),
    .rep(cpu_ep),
    .ridx(buf_addr[2:0]),
    .rdata(mem_rdata)
  );

  // ----------------------------------------
  // Read data and engine outputs
  // ----------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    unique case (io_addr)
      uer_pkg::ADDR_FUNC: rd_mux = func_reg;
      uer_pkg::ADDR_EP0_CNT: rd_mux = cnt_reg[0];
      uer_pkg::ADDR_EP0_MODE: rd_mux = mode_reg[0];
      uer_pkg::ADDR_EP1_CNT: rd_mux = cnt_reg[1];
      uer_pkg::ADDR_EP1_MODE: rd_mux = mode_reg[1];
      uer_pkg::ADDR_EP2_CNT: rd_mux = cnt_reg[2];
      uer_pkg::ADDR_EP2_MODE: rd_mux = mode_reg[2];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      io_rdata <= 8'h00;
      addr_match_en <= 1'b0;
      func_addr <= 7'h00;
      ep0_resp <= 4'h0;
      ep1_resp <= 4'h0;
      ep2_resp <= 4'h0;
      bus_reset <= 1'b0;
    end else begin
      io_rdata <= io_rd ? rd_mux : 8'h00;
      addr_match_en <= func_reg[uer_pkg::ADDR_EN_BIT];
      func_addr <= func_reg[6:0];
      ep0_resp <= mode_reg[0][3:0];
      ep1_resp <= mode_reg[1][3:0];
      ep2_resp <= mode_reg[2][3:0];
      bus_reset <= bus_reset_reg;
    end
  end
endmodule

// ### uer_top_bench.sv
// Self-checking bench for the endpoint register logic
`timescale 1ns/1ps
module uer_top_bench;
  localparam int BRC = 5;
  logic core_clk = 0, srst = 1, io_wr = 0, io_rd = 0, mem_wr = 0, mem_rd = 0;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, mem_addr = 8'h00, mem_wdata = 8'h00, io_rdata, mem_rdata;
  logic dp_pin, dm_pin, setup_data_start, setup_ack_start, txn_valid, rx_valid, rx_ready, addr_match_en, bus_reset;
  logic [6:0] func_addr;
  logic [3:0] ep0_resp, ep1_resp, ep2_resp;
  uer_pkg::uer_txn_t txn;
  uer_pkg::uer_wbyte_t rx_byte;
  logic [7:0] qio[$], qmem[$], ev[8];
  logic io_pend = 0, mem_pend = 0;
  int errors = 0, tests_run = 0, seed = 32'h71ed, i;
  always #50 core_clk = ~core_clk;
  uer_top #(.BUS_RESET_CYC(BRC)) uer_top_inst (.core_clk, .srst, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata,
    .mem_wr, .mem_addr, .mem_wdata, .mem_rd, .mem_rdata, .dp_pin, .dm_pin, .setup_data_start, .setup_ack_start,
    .txn_valid, .txn, .rx_valid, .rx_byte, .rx_ready, .addr_match_en, .func_addr, .ep0_resp, .ep1_resp, .ep2_resp,
    .bus_reset);
  uer_eng uer_eng_inst (.core_clk, .setup_data_start, .setup_ack_start, .txn_valid, .txn, .rx_valid, .rx_byte,
    .rx_ready, .dp_pin, .dm_pin);
  task automatic cmp_reg;
    logic [7:0] e;
    e = qio.pop_front();
    tests_run++;
    if (io_rdata !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: register %h expected %h", $time, io_rdata, e);
    end
  endtask
  task automatic cmp_buf;
    logic [7:0] e;
    e = qmem.pop_front();
    tests_run++;
    if (mem_rdata !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: buffer %h expected %h", $time, mem_rdata, e);
    end
  endtask
  always @(negedge core_clk) begin
    if (io_pend) cmp_reg();
    if (mem_pend) cmp_buf();
    io_pend = io_rd && !srst;
    mem_pend = mem_rd && !srst;
  end
  task automatic bus(input logic w, input logic m, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    {io_wr, io_rd, mem_wr, mem_rd} = {w & !m, !w & !m, w & m, !w & m};
    if (m) {mem_addr, mem_wdata} = {a, d};
    else {io_addr, io_wdata} = {a, d};
    @(posedge core_clk) #1;
    {io_wr, io_rd, mem_wr, mem_rd} = 4'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    qio.push_back(e);
    bus(0, 0, a, 8'h00);
  endtask
  task automatic mr(input logic [7:0] a, input logic [7:0] e);
    qmem.push_back(e);
    bus(0, 1, a, 8'h00);
  endtask
  task automatic do_reset;
    srst = 1;
    repeat (4) @(posedge core_clk);
    #1 srst = 0;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(3000 * 100);
    errors++;
    report_and_stop();
  end
  initial begin
    do_reset();
    for (i = 0; i < 7; i++) rd(8'h10 + i[7:0], 8'h00);
    for (i = 0; i < 7; i++) begin
      ev[i] = 8'($random(seed));
      if (i % 2 == 1) ev[i] = {ev[i][7:6], 2'b00, 4'(ev[i][3:0] % 9)};
      if (i == 0) ev[i][0] = 1'b1;
      if (i == 2) ev[i] = {4'h0, ev[i][3:0]};
      bus(1, 0, 8'h10 + i[7:0], ev[i]);
      if (i == 4 || i == 6) ev[i] &= uer_pkg::EP12_MODE_MASK;
      rd(8'h10 + i[7:0], ev[i]);
    end
    rd(8'h17, 8'h00);
    bus(1, 1, uer_pkg::BUF_EP0_BASE, 8'h11);
    uer_eng_inst.pulse(0);
    bus(1, 0, uer_pkg::ADDR_EP0_MODE, ev[2]);
    uer_eng_inst.send(2'd0, 3'd0, 8'ha5);
    bus(1, 1, uer_pkg::BUF_EP0_BASE, 8'h22);
    bus(1, 1, uer_pkg::BUF_EP1_BASE, 8'h33);
    uer_eng_inst.pulse(1);
    uer_eng_inst.report(2'd0, uer_pkg::TOK_SETUP, 1'b1, 4'h8, 1'b0);
    bus(1, 0, uer_pkg::ADDR_EP0_MODE, 8'h00);
    bus(1, 0, uer_pkg::ADDR_EP0_CNT, 8'h00);
    rd(uer_pkg::ADDR_EP0_MODE, 8'h90 | ev[2]);
    rd(uer_pkg::ADDR_EP0_CNT, 8'h48);
    mr(uer_pkg::BUF_EP0_BASE, 8'ha5);
    mr(uer_pkg::BUF_EP1_BASE, 8'h33);
    bus(1, 0, uer_pkg::ADDR_EP0_MODE, 8'h02);
    rd(uer_pkg::ADDR_EP0_MODE, 8'h02);
    bus(1, 1, uer_pkg::BUF_EP0_BASE, 8'h44);
    mr(uer_pkg::BUF_EP0_BASE, 8'h44);
    uer_eng_inst.report(2'd0, uer_pkg::TOK_OUT, 1'b1, 4'h3, 1'b1);
    uer_eng_inst.report(2'd0, uer_pkg::TOK_IN, 1'b0, 4'h0, 1'b0);
    rd(uer_pkg::ADDR_EP0_MODE, 8'h72);
    rd(uer_pkg::ADDR_EP0_CNT, 8'hc3);
    uer_eng_inst.report(2'd1, uer_pkg::TOK_IN, 1'b0, 4'h0, 1'b1);
    rd(uer_pkg::ADDR_EP1_MODE, ev[4] | 8'h10);
    rd(uer_pkg::ADDR_EP1_CNT, ev[3]);
    uer_eng_inst.report(2'd2, uer_pkg::TOK_OUT, 1'b1, 4'h4, 1'b1);
    rd(uer_pkg::ADDR_EP2_CNT, 8'hc4);
    for (i = 0; i < 8; i++) ev[i] = 8'($random(seed));
    fork
      for (int k = 0; k < 8; k++) uer_eng_inst.send(2'd2, k[2:0], ev[k]);
      for (int k = 0; k < 4; k++) bus(1, 1, uer_pkg::BUF_EP1_BASE + 8'(k), 8'h60 + 8'(k));
    join
    for (i = 0; i < 8; i++) mr(uer_pkg::BUF_EP2_BASE + i[7:0], ev[i]);
    mr(uer_pkg::BUF_EP1_BASE + 8'h03, 8'h63);
    bus(1, 0, uer_pkg::ADDR_FUNC, 8'h85);
    uer_eng_inst.se0(BRC - 2);
    repeat (8) @(posedge core_clk);
    rd(uer_pkg::ADDR_FUNC, 8'h85);
    uer_eng_inst.se0(BRC + 12);
    repeat (8) @(posedge core_clk);
    rd(uer_pkg::ADDR_FUNC, 8'h00);
    do_reset();
    rd(uer_pkg::ADDR_EP0_MODE, 8'h00);
    repeat (3) @(posedge core_clk);
    report_and_stop();
  end
endmodule

// ### uer_top_sva.sv
// Port assertions for the endpoint register logic
`timescale 1ns/1ps
module uer_top_sva #(
  parameter int BUS_RESET_CYC = 81
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Processor port
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // Engine side
  input wire logic dp_pin,
  input wire logic dm_pin,
  input wire logic setup_data_start,
  input wire logic rx_valid,
  input wire logic rx_ready,
  // Register view
  input wire logic addr_match_en,
  input wire logic [6:0] func_addr,
  input wire logic [3:0] ep0_resp,
  input wire logic [3:0] ep1_resp,
  input wire logic [3:0] ep2_resp,
  input wire logic bus_reset
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  logic pend_reg;
  int se0_reg;
  // Setup pending until first mode read; raw line-low count
  always_ff @(posedge core_clk) begin
    if (srst || (io_rd && io_addr == uer_pkg::ADDR_EP0_MODE)) pend_reg <= 1'b0;
    else if (setup_data_start) pend_reg <= 1'b1;
    if (dp_pin || dm_pin) se0_reg <= 0;
    else if (se0_reg < 500) se0_reg <= se0_reg + 1;
  end
  a_addr_bus_clear: assert property ($rose(bus_reset) |-> ##[0:3] (func_addr == 7'h00 && !addr_match_en))
    else $error("address kept after bus reset");
  a_mode_reset_zero: assert property ($fell(srst) |-> ep0_resp == 4'h0 && func_addr == 7'h00)
    else $error("registers not cleared by reset");
  a_addr_enable_set: assert property (io_wr && io_addr == uer_pkg::ADDR_FUNC |->
    ##2 (addr_match_en == $past(io_wdata[7], 2) && func_addr == $past(io_wdata[6:0], 2)))
    else $error("address enable not taken from write");
  a_ep12_reserved: assert property (io_rd && (io_addr == uer_pkg::ADDR_EP1_MODE ||
    io_addr == uer_pkg::ADDR_EP2_MODE) |=> io_rdata[7:5] == 3'b000)
    else $error("reserved mode bits read nonzero");
  a_setup_held: assert property (pend_reg && io_rd && io_addr == uer_pkg::ADDR_EP0_MODE |=> io_rdata[7])
    else $error("setup flag lost before first read");
  a_rx_one_word: assert property (rx_valid && rx_ready |=> !rx_ready)
    else $error("ready kept while buffer holds byte");
  a_busrst_late: assert property ($rose(bus_reset) |-> se0_reg >= BUS_RESET_CYC)
    else $error("bus reset seen too early");
  a_busrst_on: assert property (se0_reg == BUS_RESET_CYC + 8 |-> bus_reset)
    else $error("bus reset missed");
  a_ep1_resp_follows: assert property (io_wr && io_addr == uer_pkg::ADDR_EP1_MODE |->
    ##2 ep1_resp == $past(io_wdata[3:0], 2))
    else $error("endpoint one response not taken from write");
  a_ep2_resp_follows: assert property (io_wr && io_addr == uer_pkg::ADDR_EP2_MODE |->
    ##2 ep2_resp == $past(io_wdata[3:0], 2))
    else $error("endpoint two response not taken from write");
  c_setup_read: cover property (pend_reg && io_rd && io_addr == uer_pkg::ADDR_EP0_MODE);
  c_bus_reset: cover property ($rose(bus_reset));
  c_rx_stall: cover property (rx_valid && !rx_ready);
endmodule
bind uer_top uer_top_sva #(.BUS_RESET_CYC(BUS_RESET_CYC)) uer_top_sva_inst (.core_clk, .srst, .io_wr, .io_rd,
  .io_addr, .io_wdata, .io_rdata, .dp_pin, .dm_pin, .setup_data_start, .rx_valid, .rx_ready, .addr_match_en,
  .func_addr, .ep0_resp, .ep1_resp, .ep2_resp, .bus_reset);
